//--- src/bpgfc_top.v
// buck regulator power-good, status and fault control
`timescale 1ns/1ps
`include "bpgfc_defs.vh"
module bpgfc_top #(
	parameter HICCUP_CYC = `BPGFC_HICCUP_US * `BPGFC_CLK_MHZ
) (
	input  wire       mclk,
	input  wire       rst,
	input  wire       internal_enable,
	input  wire       servo_busy,
	input  wire       ref_write,
	input  wire       ref_down,
	input  wire       light_load,
	input  wire       cc_regulating,
	input  wire       cc_exit_threshold,
	input  wire       cv_window_upper,
	input  wire       cv_window_lower,
	input  wire       over_voltage_threshold,
	input  wire       uv_threshold_current_mode,
	input  wire       uv_threshold_voltage_mode,
	input  wire       cycle_limit_upper,
	input  wire       cycle_limit_lower,
	input  wire       pwm_start,
	input  wire       reg_hs_cmd,
	input  wire       reg_ls_cmd,
	input  wire [7:0] config_byte_one,
	input  wire [7:0] config_byte_two,
	input  wire [7:0] config_byte_three,
	input  wire [7:0] config_byte_four,
	input  wire       int1_clear,
	input  wire       int2_clear,
	output wire       power_good_out_o,
	output wire       power_good_out_oe,
	output reg  [7:0] status_byte_q,
	output reg  [7:0] interrupt_byte_one_q,
	output reg  [7:0] interrupt_byte_two_q,
	output reg  [2:0] state_q,
	output reg        servo_start_q,
	output reg        hs_gate_q,
	output reg        ls_gate_q,
	output reg        discharge_resistor_q,
	output reg  [1:0] slew_sel_q,
	output reg        cc_allow_q,
	output reg        over_current_fault_q,
	output reg        over_voltage_fault_q,
	output reg        under_voltage_fault_q
);
	reg  [2:0]  state_d;
	reg  [15:0] hic_q;
	reg         cc_mode_q;
	wire        run = (state_q == `BPGFC_ST_ON) ||
	                  (state_q == `BPGFC_ST_SERVO);
	wire        limit_active;
	wire        cbc_cont;
	wire        oc_event;
	wire        pg_pin;
	wire        uv_now;
	wire        uv_off = config_byte_two[`BPGFC_CFG2_UVOFF];
	wire        latch_sel = config_byte_two[`BPGFC_CFG2_LATCH];
	wire        cc_mode_d = cc_regulating | cbc_cont;
	wire        uv_act;
	wire        pg_decision;

	bpgfc_cycle_limit u_cbc (
		.mclk              (mclk),
		.rst               (rst),
		.run               (run),
		.cycle_limit_upper (cycle_limit_upper),
		.cycle_limit_lower (cycle_limit_lower),
		.pwm_start         (pwm_start),
		.limit_active_q    (limit_active),
		.continuous_q      (cbc_cont),
		.oc_event          (oc_event)
	);

	// servo running blanks the decision, whatever reference moves
	assign pg_decision = (state_q == `BPGFC_ST_ON) & ~servo_busy;

	bpgfc_pg_delay u_pgd (
		.mclk        (mclk),
		.rst         (rst),
		.pg_decision (pg_decision),
		.delay_sel   (config_byte_one[`BPGFC_CFG1_DLY_HI:`BPGFC_CFG1_DLY_LO]),
		.pg_pin_q    (pg_pin)
	);

	// open drain: only ever pull low
	assign power_good_out_o  = 1'b0;
	assign power_good_out_oe = ~pg_pin;

	assign uv_now = config_byte_three[`BPGFC_CFG3_UVSEL] ?
	                uv_threshold_voltage_mode :
	                uv_threshold_current_mode;
	// uv action only while switching runs (servo or on state); flag and interrupt take uv_now directly
	assign uv_act = run & uv_now & ~uv_off;

	always @* begin
		state_d = state_q;
		case (state_q)
			`BPGFC_ST_IDLE:
				if (internal_enable)
					state_d = `BPGFC_ST_SERVO;
			`BPGFC_ST_SERVO, `BPGFC_ST_ON: begin
				if (!internal_enable)
					state_d = `BPGFC_ST_IDLE;
				else if (oc_event || (run && over_voltage_threshold))
					state_d = `BPGFC_ST_LATCH;
				else if (uv_act)
					state_d = latch_sel ? `BPGFC_ST_LATCH :
					          `BPGFC_ST_HICCUP;
				else if (servo_busy || ref_write)
					state_d = `BPGFC_ST_SERVO;
				else
					state_d = `BPGFC_ST_ON;
			end
			`BPGFC_ST_HICCUP:
				// leaves for servo after HICCUP_CYC cycles to retry, or for idle when enable drops
				if (!internal_enable)
					state_d = `BPGFC_ST_IDLE;
				else if (hic_q == HICCUP_CYC[15:0] - 16'h0001)
					state_d = `BPGFC_ST_SERVO;
			`BPGFC_ST_LATCH:
				if (!internal_enable)
					state_d = `BPGFC_ST_IDLE;
			default:
				state_d = `BPGFC_ST_IDLE;
		endcase
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q               <= `BPGFC_ST_IDLE;
			hic_q                 <= 16'h0000;
			cc_mode_q             <= 1'b0;
			status_byte_q         <= 8'h00;
			interrupt_byte_one_q  <= 8'h00;
			interrupt_byte_two_q  <= 8'h00;
			servo_start_q         <= 1'b0;
			hs_gate_q             <= 1'b0;
			ls_gate_q             <= 1'b0;
			discharge_resistor_q  <= 1'b0;
			slew_sel_q            <= 2'h0;
			cc_allow_q            <= 1'b0;
			over_current_fault_q  <= 1'b0;
			over_voltage_fault_q  <= 1'b0;
			under_voltage_fault_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == `BPGFC_ST_HICCUP)
				hic_q <= hic_q + 16'h0001;
			else
				hic_q <= 16'h0000;
			servo_start_q <= run & internal_enable & ref_write;
			cc_mode_q <= cc_mode_d;
			status_byte_q <= 8'h00;
			status_byte_q[`BPGFC_STAT_CC] <= cc_mode_d;
			status_byte_q[`BPGFC_STAT_WIN] <=
				~cv_window_upper & cv_window_lower;
			// set wins over a clear in the same cycle
			if (int1_clear)
				interrupt_byte_one_q <= 8'h00;
			if (cc_mode_d != cc_mode_q)
				interrupt_byte_one_q[`BPGFC_INT1_MODE] <= 1'b1;
			if (int2_clear)
				interrupt_byte_two_q <= 8'h00;
			if (oc_event)
				interrupt_byte_two_q[`BPGFC_INT2_OC] <= 1'b1;
			if (run && over_voltage_threshold)
				interrupt_byte_two_q[`BPGFC_INT2_OV] <= 1'b1;
			if (uv_now)
				interrupt_byte_two_q[`BPGFC_INT2_UV] <= 1'b1;
			over_current_fault_q  <= oc_event |
				(over_current_fault_q & internal_enable);
			over_voltage_fault_q  <= run & over_voltage_threshold;
			under_voltage_fault_q <= uv_now;
			// gate drive: limit event overrides regulation commands
			if (!run) begin
				hs_gate_q <= 1'b0;
				ls_gate_q <= 1'b0;
			end else if (limit_active || (cycle_limit_upper)) begin
				hs_gate_q <= 1'b0;
				ls_gate_q <= 1'b1;
			end else begin
				hs_gate_q <= reg_hs_cmd;
				ls_gate_q <= reg_ls_cmd & ~reg_hs_cmd;
			end
			discharge_resistor_q <= config_byte_two[`BPGFC_CFG2_DIS] &
				(state_q == `BPGFC_ST_SERVO) & ref_down & light_load;
			slew_sel_q <=
				config_byte_four[`BPGFC_CFG4_SR_HI:`BPGFC_CFG4_SR_LO];
			// with uv action off cc runs until the exit comparator drops
			cc_allow_q <= run & cc_exit_threshold &
				(uv_off | ~uv_now);
		end
	end
endmodule // bpgfc_top

//--- src/bpgfc_defs.vh
// constants for the buck power-good and fault control block
// Operation
// - power_good_out high only in the main regulator on state, low otherwise
// - power-good held low whenever the reference servo runs
// - servo blanking applies for voltage or current reference, any mode
// - status bit 4 shows constant-current (1) or constant-voltage (0) mode
// - status bit 2 shows output inside the constant-voltage window
// - interrupt byte one bit 7 set on each cv/cc mode change
// - power-good pin delayed by amount chosen by config byte one bits 7:6
// - new voltage/current targets accepted while enabled, reached through servo
// - config byte two bit 5 enables discharge resistor on downward voltage steps at light load
// - config byte four bits 3:2 select the switch node slew rate
// - upper limit forces low side on until current below lower limit
// - during a cycle limit event, regulation commands to gates are ignored
// - continuous cycle limiting is reported as constant-current mode
// - four consecutive limit pairs raise over-current fault, interrupt two bit 6
// - feedback above over-voltage threshold raises fault, interrupt two bit 5
// - feedback below chosen under-voltage threshold raises fault, bit 4
// - config byte three bit 3 picks uv threshold: 0 current, 1 voltage
// - config byte two bit 3 suppresses uv action; flag and interrupt remain
// - with uv action off, cc regulation runs down to cc exit threshold
// - config two bit 2 low: uv fault stops switching for hiccup, then retries
// - config two bit 2 high: uv fault latches regulator off
// - after latch-off regulator stays off until internal enable goes low
`ifndef BPGFC_DEFS_VH
`define BPGFC_DEFS_VH
`define BPGFC_ST_IDLE     3'h0
`define BPGFC_ST_SERVO    3'h1
`define BPGFC_ST_ON       3'h2
`define BPGFC_ST_HICCUP   3'h3
`define BPGFC_ST_LATCH    3'h4
`define BPGFC_STAT_CC     4
`define BPGFC_STAT_WIN    2
`define BPGFC_INT1_MODE   7
`define BPGFC_INT2_OC     6
`define BPGFC_INT2_OV     5
`define BPGFC_INT2_UV     4
`define BPGFC_CFG1_DLY_HI 7
`define BPGFC_CFG1_DLY_LO 6
`define BPGFC_CFG2_DIS    5
`define BPGFC_CFG2_UVOFF  3
`define BPGFC_CFG2_LATCH  2
`define BPGFC_CFG3_UVSEL  3
`define BPGFC_CFG4_SR_HI  3
`define BPGFC_CFG4_SR_LO  2
`define BPGFC_OC_PAIRS    3'h4
`define BPGFC_HICCUP_US   16'h0064
`define BPGFC_PG_D0_US    20'h00000
`define BPGFC_PG_D1_US    20'h00064
`define BPGFC_PG_D2_US    20'h003e8
`define BPGFC_PG_D3_US    20'h02710
`define BPGFC_CLK_MHZ     10
`endif

//--- src/bpgfc_pg_delay.v
// power-good delay filter with restartable counter
`timescale 1ns/1ps
`include "bpgfc_defs.vh"
module bpgfc_pg_delay #(
	parameter CW = 20,
	parameter D1 = `BPGFC_PG_D1_US * `BPGFC_CLK_MHZ,
	parameter D2 = `BPGFC_PG_D2_US * `BPGFC_CLK_MHZ,
	parameter D3 = `BPGFC_PG_D3_US * `BPGFC_CLK_MHZ
) (
	input  wire       mclk,
	input  wire       rst,
	input  wire       pg_decision,
	input  wire [1:0] delay_sel,
	output reg        pg_pin_q
);
	reg [CW-1:0] cnt_q;
	reg          last_q;
	reg [CW-1:0] limit;
	always @* begin
		case (delay_sel)
			2'h1: limit = D1[CW-1:0];
			2'h2: limit = D2[CW-1:0];
			2'h3: limit = D3[CW-1:0];
			default: limit = {CW{1'b0}};
		endcase
	end
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q    <= {CW{1'b0}};
			last_q   <= 1'b0;
			pg_pin_q <= 1'b0;
		end else begin
			last_q <= pg_decision;
			// delay covers the rise only: servo or fault drops pg at once
			if (!pg_decision) begin
				cnt_q    <= {CW{1'b0}};
				pg_pin_q <= 1'b0;
			end else if (pg_decision != last_q) begin
				cnt_q <= {CW{1'b0}};
			end else if (cnt_q >= limit) begin
				pg_pin_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // bpgfc_pg_delay

//--- src/bpgfc_cycle_limit.v
// cycle-by-cycle limit latch and over-current pair counter
`timescale 1ns/1ps
`include "bpgfc_defs.vh"
module bpgfc_cycle_limit (
	input  wire mclk,
	input  wire rst,
	input  wire run,
	input  wire cycle_limit_upper,
	input  wire cycle_limit_lower,
	input  wire pwm_start,
	output reg  limit_active_q,
	output reg  continuous_q,
	output wire oc_event
);
	reg [2:0] pairs_q;
	reg       hit_q;
	wire      pair_done = limit_active_q & ~cycle_limit_lower;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			limit_active_q <= 1'b0;
			pairs_q        <= 3'h0;
			hit_q          <= 1'b0;
			continuous_q   <= 1'b0;
		end else if (!run) begin
			limit_active_q <= 1'b0;
			pairs_q        <= 3'h0;
			hit_q          <= 1'b0;
			continuous_q   <= 1'b0;
		end else begin
			if (!limit_active_q && cycle_limit_upper)
				limit_active_q <= 1'b1;
			else if (pair_done)
				limit_active_q <= 1'b0;
			if (pair_done) begin
				hit_q <= 1'b1;
				if (pairs_q != `BPGFC_OC_PAIRS)
					pairs_q <= pairs_q + 3'h1;
			end else if (pwm_start) begin
				// a cycle without a pair breaks the run
				if (!hit_q)
					pairs_q <= 3'h0;
				continuous_q <= hit_q;
				hit_q <= 1'b0;
			end
		end
	end
	assign oc_event = pair_done && (pairs_q == `BPGFC_OC_PAIRS - 3'h1);
endmodule // bpgfc_cycle_limit

//--- tb/bpgfc_host_model.sv
// host and board model: pg pull-up, enable and hiccup watchdog
`timescale 1ns/1ps
`include "bpgfc_defs.vh"
module bpgfc_host_model #(
	parameter MAX_HIC = 3
) (
	input  logic       mclk,
	input  logic       rst,
	input  logic       en_req,
	input  logic [2:0] state_q,
	input  logic       power_good_out_oe,
	input  logic       power_good_out_o,
	output logic       internal_enable,
	output wire        pg_level
);
	logic [2:0] hic_q;
	logic       in_hic_q;
	// board pull-up: a released pin reads high
	assign pg_level = power_good_out_oe ? power_good_out_o : 1'b1;
	// the block retries after each hiccup wait, so the host counts hiccup entries and quits after MAX_HIC
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			hic_q <= 3'h0;
			in_hic_q <= 1'b0;
			internal_enable <= 1'b0;
		end else begin
			in_hic_q <= (state_q == `BPGFC_ST_HICCUP);
			if (!en_req)
				hic_q <= 3'h0;
			else if (state_q == `BPGFC_ST_HICCUP && !in_hic_q)
				hic_q <= hic_q + 3'h1;
			internal_enable <= en_req && (hic_q < MAX_HIC);
		end
	end
endmodule // bpgfc_host_model

//--- tb/bpgfc_chk_sva.sv
// checker for the power-good and fault control ports
`timescale 1ns/1ps
`include "bpgfc_defs.vh"
module bpgfc_chk (
	input logic       mclk,
	input logic       rst,
	input logic       internal_enable,
	input logic       servo_busy,
	input logic       cc_regulating,
	input logic       uv_threshold_current_mode,
	input logic       uv_threshold_voltage_mode,
	input logic       cycle_limit_upper,
	input logic       cycle_limit_lower,
	input logic [7:0] config_byte_one,
	input logic [7:0] config_byte_three,
	input logic       power_good_out_oe,
	input logic [7:0] status_byte_q,
	input logic [7:0] interrupt_byte_one_q,
	input logic [7:0] interrupt_byte_two_q,
	input logic [2:0] state_q,
	input logic       hs_gate_q,
	input logic       ls_gate_q,
	input logic       over_current_fault_q
);
	localparam logic [2:0] S_ON = `BPGFC_ST_ON;
	localparam logic [2:0] S_LT = `BPGFC_ST_LATCH;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_pg_rise_on: assert property ($fell(power_good_out_oe) |->
		$past(state_q) == S_ON || $past(state_q, 2) == S_ON)
		else $error("pg rose outside on");
	a_servo_blank: assert property (servo_busy [*2]
		|-> power_good_out_oe) else $error("pg high during servo");
	a_status_cc: assert property (!$past(rst)
		&& $past(cc_regulating) |-> status_byte_q[4])
		else $error("cc status bit missing");
	a_mode_irq: assert property (!$past(rst)
		&& $changed(status_byte_q[4]) |-> ##[0:1] interrupt_byte_one_q[7])
		else $error("mode change irq missing");
	a_oc_irq: assert property ($rose(over_current_fault_q)
		|-> ##[0:1] interrupt_byte_two_q[6]) else $error("oc irq missing");
	a_uv_irq: assert property ((config_byte_three[3] ?
		uv_threshold_voltage_mode : uv_threshold_current_mode)
		|-> ##[1:2] interrupt_byte_two_q[4]) else $error("uv irq missing");
	a_limit_gates: assert property ((state_q == S_ON &&
		cycle_limit_upper) ##1 cycle_limit_lower [*2]
		|-> ##[0:1] (!hs_gate_q && ls_gate_q))
		else $error("limit gates wrong");
	a_latch_holds: assert property (state_q == S_LT &&
		internal_enable |=> state_q == S_LT)
		else $error("latch left while enabled");
	cover property (state_q == `BPGFC_ST_HICCUP);
	cover property ($rose(over_current_fault_q));
	cover property ($fell(power_good_out_oe));
endmodule // bpgfc_chk
bind bpgfc_top bpgfc_chk u_chk (.*);

//--- tb/test_bpgfc_top.sv
// bench: sequences of pin settings and checks for bpgfc_top
`timescale 1ns/1ps
`include "bpgfc_defs.vh"
module test_bpgfc_top;
	logic       mclk, rst, en_req, servo_busy, ref_write, ref_down;
	logic       light_load, cc_regulating, cc_exit_threshold, pwm_start;
	logic       cv_window_upper, cv_window_lower, over_voltage_threshold;
	logic       uv_threshold_current_mode, uv_threshold_voltage_mode;
	logic       cycle_limit_upper, cycle_limit_lower, reg_hs_cmd;
	logic       reg_ls_cmd, int1_clear, int2_clear;
	logic [7:0] config_byte_one, config_byte_two;
	logic [7:0] config_byte_three, config_byte_four;
	wire        internal_enable, power_good_out_o, power_good_out_oe;
	wire        pg_level, servo_start_q, hs_gate_q, ls_gate_q, cc_allow_q;
	wire        discharge_resistor_q, over_current_fault_q;
	wire        over_voltage_fault_q, under_voltage_fault_q;
	wire [7:0]  status_byte_q, interrupt_byte_one_q, interrupt_byte_two_q;
	wire [2:0]  state_q;
	wire [1:0]  slew_sel_q;
	int         err_total, n_tests, k;
	// short hiccup wait keeps the retry loop to a few dozen cycles
	bpgfc_top #(.HICCUP_CYC(8)) u_dut (.*);
	bpgfc_host_model u_host (.*);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task wait_st(input logic [2:0] s);
		for (k = 0; state_q !== s && k < 300; k++)
			tick(1);
		chk("state", state_q, s);
	endtask
	task servo_on;
		ref_write <= 1'b1;
		servo_busy <= 1'b1;
		tick(1);
		ref_write <= 1'b0;
		tick(1);
		chk("servo_start", servo_start_q, 1);
		tick(2);
	endtask
	task up;
		en_req <= 1'b0;
		tick(2);
		en_req <= 1'b1;
		wait_st(`BPGFC_ST_ON);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		{en_req, servo_busy, ref_write, ref_down, light_load, cc_regulating,
		 cc_exit_threshold, pwm_start, cv_window_upper, cv_window_lower,
		 over_voltage_threshold, uv_threshold_current_mode,
		 uv_threshold_voltage_mode, cycle_limit_upper, cycle_limit_lower,
		 reg_hs_cmd, reg_ls_cmd, int1_clear, int2_clear, config_byte_one,
		 config_byte_two, config_byte_three, config_byte_four} = '0;
		rst = 1'b1;
		tick(2);
		chk("pg_oe", power_good_out_oe, 1);
		rst <= 1'b0;
		en_req <= 1'b1;
		servo_busy <= 1'b1;
		tick(4);
		chk("state", state_q, `BPGFC_ST_SERVO);
		chk("pg", pg_level, 0);
		servo_busy <= 1'b0;
		wait_st(`BPGFC_ST_ON);
		tick(4);
		chk("pg", pg_level, 1);
		$display("test power_up done");
		// downward target in cc mode at light load
		{cc_regulating, ref_down, light_load} <= 3'h7;
		config_byte_two <= 8'h20;
		servo_on;
		chk("state", state_q, `BPGFC_ST_SERVO);
		chk("pg", pg_level, 0);
		chk("discharge", discharge_resistor_q, 1);
		chk("cc", status_byte_q[4], 1);
		chk("mode_irq", interrupt_byte_one_q[7], 1);
		{servo_busy, ref_down, cv_window_lower, int1_clear} <= 4'h3;
		config_byte_four <= 8'h0c;
		tick(1);
		int1_clear <= 1'b0;
		wait_st(`BPGFC_ST_ON);
		chk("window", status_byte_q[2], 1);
		chk("slew", slew_sel_q, 3);
		chk("irq1", interrupt_byte_one_q, 0);
		$display("test servo_status done");
		// a second servo mid-delay must restart the count
		config_byte_one <= 8'h40;
		servo_on;
		servo_busy <= 1'b0;
		tick(500);
		chk("pg", pg_level, 0);
		servo_on;
		servo_busy <= 1'b0;
		for (k = 0; power_good_out_oe !== 1'b0 && k < 1200; k++)
			tick(1);
		chk("pg_delay", k >= 1000 && k <= 1008, 1);
		config_byte_one <= 8'h00;
		$display("test pg_delay done");
		// four limit pairs with the regulation command high, cc loop idle
		reg_hs_cmd <= 1'b1;
		cc_regulating <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			{pwm_start, cycle_limit_upper, cycle_limit_lower} <= 3'h7;
			tick(1);
			{pwm_start, cycle_limit_upper} <= 2'h0;
			tick(2);
			chk("gates", {hs_gate_q, ls_gate_q}, 1);
			if (i == 3)
				chk("cc_limit", status_byte_q[4], 1);
			cycle_limit_lower <= 1'b0;
			tick(1);
		end
		wait_st(`BPGFC_ST_LATCH);
		chk("oc_irq", interrupt_byte_two_q[6], 1);
		tick(20);
		chk("state", state_q, `BPGFC_ST_LATCH);
		$display("test over_current done");
		// persistent uv: hiccup retries until the host model drops enable, then idle
		config_byte_two <= 8'h00;
		config_byte_three <= 8'h08;
		up;
		uv_threshold_voltage_mode <= 1'b1;
		wait_st(`BPGFC_ST_HICCUP);
		chk("uv_irq", interrupt_byte_two_q[4], 1);
		wait_st(`BPGFC_ST_IDLE);
		uv_threshold_voltage_mode <= 1'b0;
		$display("test hiccup done");
		// uv action suppressed on the cc threshold: flag only, cc runs on
		config_byte_two <= 8'h08;
		config_byte_three <= 8'h00;
		up;
		{int2_clear, uv_threshold_current_mode, cc_exit_threshold} <= 3'h7;
		tick(1);
		int2_clear <= 1'b0;
		tick(3);
		chk("uv_irq", interrupt_byte_two_q[4], 1);
		chk("uv_flag", under_voltage_fault_q, 1);
		chk("state", state_q, `BPGFC_ST_ON);
		chk("cc_allow", cc_allow_q, 1);
		// latch option, then over-voltage
		config_byte_two <= 8'h04;
		wait_st(`BPGFC_ST_LATCH);
		uv_threshold_current_mode <= 1'b0;
		up;
		over_voltage_threshold <= 1'b1;
		wait_st(`BPGFC_ST_LATCH);
		chk("ov_irq", interrupt_byte_two_q[5], 1);
		chk("ov_fault", over_voltage_fault_q, 1);
		$display("test uv_ov done");
		tally_and_finish;
	end
endmodule // test_bpgfc_top
